// File: bas_burst_address_sequencer.sv
// Burst word-address sequencer: linear, wrapped and hybrid word orders.
`include "bas_defs.svh"

module bas_burst_address_sequencer import bas_pkg::*; #(
    parameter int ADDR_W     = `BAS_ADDR_WIDTH,
    parameter int FIFO_DEPTH = `BAS_FIFO_DEPTH
) (
    input  wire logic                      clk_in,
    input  wire logic                      sys_rst_in,
    input  wire logic                      cs_n_in,
    input  wire logic                      cmd_valid_in,
    input  wire logic [`BAS_CA_WIDTH-1:0]  command_address_word_in,
    input  wire logic [ADDR_W-1:0]         cmd_start_addr_in,
    input  wire logic [`BAS_CFG_WIDTH-1:0] cfg_reg_zero_in,
    input  wire logic                      byte_valid_in,
    output logic                           byte_ready_out,
    output logic                           word_addr_valid_out,
    output logic [ADDR_W-1:0]              word_addr_out,
    input  wire logic                      word_addr_ready_in,
    output logic                           burst_active_out
);
    // Elaboration-time check: the group base and the pass counter need eight address bits.
    if (ADDR_W < 8) begin : g_bad_addr_w
        $error("bas_burst_address_sequencer: ADDR_W must be at least 8.");
    end

    // ------------------------------------------------------------------
    // Chip select synchroniser
    // ------------------------------------------------------------------
    logic cs_n_meta_q, cs_n_sync_q;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cs_n_meta_q <= 1'b1;
            cs_n_sync_q <= 1'b1;
        end else begin
            cs_n_meta_q <= cs_n_in;
            cs_n_sync_q <= cs_n_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Group mask from the burst length code
    // ------------------------------------------------------------------
    function automatic bas_mask_t bas_mask_of(input logic [1:0] code);
        bas_mask_t m;
        m = `BAS_MASK_32;
        unique case (code)
            `BAS_BL_128: m = `BAS_MASK_128;
            `BAS_BL_64:  m = `BAS_MASK_64;
            `BAS_BL_16:  m = `BAS_MASK_16;
            `BAS_BL_32:  m = `BAS_MASK_32;
        endcase
        return m;
    endfunction : bas_mask_of

    // ------------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------------
    bas_stream_if #(.W(ADDR_W)) seq_if ();
    bas_stream_if #(.W(ADDR_W)) out_if ();

    bas_state_e         state_q, state_d;
    logic [ADDR_W-1:0]  addr_q, addr_d;
    logic [ADDR_W-1:0]  base_q, base_d;
    logic [ADDR_W-1:0]  mask_q, mask_d;
    logic [5:0]         count_q, count_d;
    logic               linear_q, linear_d;
    logic               hybrid_q, hybrid_d;
    logic               phase_q, phase_d;
    logic               word_done;
    logic [ADDR_W-1:0]  addr_inc;
    logic [ADDR_W-1:0]  wrap_next;

    // A byte that arrives after chip select has been seen high must not push an address.
    assign word_done    = (state_q == BAS_BURST) && !cs_n_sync_q && byte_valid_in
                          && seq_if.ready && phase_q;
    assign seq_if.valid = word_done;
    assign seq_if.data  = addr_q;
    assign addr_inc     = addr_q + 1'b1;
    assign wrap_next    = (addr_q & ~mask_q) | (addr_inc & mask_q);

    always_comb begin
        state_d  = state_q;
        addr_d   = addr_q;
        base_d   = base_q;
        mask_d   = mask_q;
        count_d  = count_q;
        linear_d = linear_q;
        hybrid_d = hybrid_q;
        phase_d  = phase_q;
        unique case (state_q)
            BAS_IDLE: begin
                // The command is only honoured while the device is selected.
                if (cmd_valid_in && !cs_n_sync_q) begin
                    state_d  = BAS_BURST;
                    addr_d   = cmd_start_addr_in;
                    mask_d   = ADDR_W'(bas_mask_of(
                        cfg_reg_zero_in[`BAS_CFG_BL_MSB:`BAS_CFG_BL_LSB]));
                    base_d   = cmd_start_addr_in & ~ADDR_W'(bas_mask_of(
                        cfg_reg_zero_in[`BAS_CFG_BL_MSB:`BAS_CFG_BL_LSB]));
                    linear_d = command_address_word_in[`BAS_CA_TYPE_BIT];
                    hybrid_d = !cfg_reg_zero_in[`BAS_CFG_HYB_BIT];
                    count_d  = '0;
                    phase_d  = 1'b0;
                end
            end
            BAS_BURST: begin
                if (cs_n_sync_q) begin
                    state_d = BAS_IDLE;
                end else if (byte_valid_in && seq_if.ready) begin
                    phase_d = !phase_q;
                    if (phase_q) begin
                        count_d = count_q + 1'b1;
                        if (linear_q) begin
                            addr_d = addr_inc;
                        end else if (hybrid_q && count_q == mask_q[5:0]) begin
                            // Pass done: first word past the group, then linear.
                            addr_d   = base_q + mask_q + 1'b1;
                            linear_d = 1'b1;
                        end else begin
                            addr_d = wrap_next;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_q  <= BAS_IDLE;
            addr_q   <= '0;
            base_q   <= '0;
            mask_q   <= '0;
            count_q  <= '0;
            linear_q <= 1'b0;
            hybrid_q <= 1'b0;
            phase_q  <= 1'b0;
        end else begin
            state_q  <= state_d;
            addr_q   <= addr_d;
            base_q   <= base_d;
            mask_q   <= mask_d;
            count_q  <= count_d;
            linear_q <= linear_d;
            hybrid_q <= hybrid_d;
            phase_q  <= phase_d;
        end
    end

    // ------------------------------------------------------------------
    // Address FIFO and registered output stage
    // ------------------------------------------------------------------
    // The FIFO absorbs consumer stalls; when it fills, byte_ready_out drops
    // and the byte source must hold its data.
    bas_fifo #(
        .W     (ADDR_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .wr         (seq_if.snk),
        .rd         (out_if.src)
    );

    logic              out_valid_q, out_valid_d;
    logic [ADDR_W-1:0] out_data_q, out_data_d;
    logic              active_q, active_d;

    assign out_if.ready = !out_valid_q || word_addr_ready_in;

    always_comb begin
        out_valid_d = out_valid_q;
        out_data_d  = out_data_q;
        if (out_if.ready) begin
            out_valid_d = out_if.valid;
            out_data_d  = out_if.valid ? out_if.data : out_data_q;
        end
        active_d = (state_d == BAS_BURST);
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            out_valid_q <= 1'b0;
            out_data_q  <= '0;
            active_q    <= 1'b0;
        end else begin
            out_valid_q <= out_valid_d;
            out_data_q  <= out_data_d;
            active_q    <= active_d;
        end
    end

    assign byte_ready_out      = seq_if.ready;
    assign word_addr_valid_out = out_valid_q;
    assign word_addr_out       = out_data_q;
    assign burst_active_out    = active_q;

endmodule : bas_burst_address_sequencer

// File: bas_defs.svh
// Constants of the burst address sequencer: field positions, codes and sizes.
//
// Summary of operation
// - Burst-type bit one: linear increment, no wrap.
// - Sixteen-byte wrap: eight words, wrap inside group.
// - Thirty-two-byte wrap: sixteen words cycled in group.
// - Sixty-four-byte wrap: thirty-two words, 1F back to 00.
// - 128-byte wrap: sixty-four words, 3F back to 00.
// - 128-byte hybrid: after one pass continue linearly.
// - 64-byte hybrid: after pass continue at word 20.
// - 16-byte hybrid: after pass continue at word 08.
// - Length code 00=128,01=64,10=16,11=32 bytes.
// - Config bit 2 zero selects hybrid wrapped ordering.
// - Linear continuation runs until chip select rises.
`ifndef BAS_DEFS_SVH
`define BAS_DEFS_SVH

`define BAS_CA_WIDTH        48
`define BAS_CA_TYPE_BIT     45
`define BAS_CFG_WIDTH       16
`define BAS_CFG_BL_MSB      1
`define BAS_CFG_BL_LSB      0
`define BAS_CFG_HYB_BIT     2
`define BAS_BL_128          2'h0
`define BAS_BL_64           2'h1
`define BAS_BL_16           2'h2
`define BAS_BL_32           2'h3
`define BAS_MASK_128        6'h3F
`define BAS_MASK_64         6'h1F
`define BAS_MASK_32         6'h0F
`define BAS_MASK_16         6'h07
`define BAS_FIFO_DEPTH      16
`define BAS_ADDR_WIDTH      32

`endif

// File: bas_pkg.sv
// Types shared by the burst address sequencer modules.
package bas_pkg;

    typedef enum logic [0:0] {
        BAS_IDLE,
        BAS_BURST
    } bas_state_e;

    typedef logic [5:0] bas_mask_t;

endpackage : bas_pkg

// File: bas_stream_if.sv
// Valid/ready word stream between the sequencer and its FIFO.
interface bas_stream_if #(
    parameter int W = 32
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : bas_stream_if

// File: bas_fifo.sv
// Flip-flop FIFO with valid/ready on both sides and a registered not-full flag.
module bas_fifo import bas_pkg::*; #(
    parameter int W     = 32,
    parameter int DEPTH = 16
) (
    input  wire logic   clk_in,
    input  wire logic   sys_rst_in,
    bas_stream_if.snk   wr,
    bas_stream_if.src   rd
);
    localparam int PW = $clog2(DEPTH);

    // Elaboration-time check: the pointers wrap naturally only for a power-of-two depth.
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
        $error("bas_fifo: DEPTH must be a power of two of at least 2.");
    end

    logic [W-1:0]  mem_q [DEPTH];
    logic [PW-1:0] wr_ptr_q, wr_ptr_d;
    logic [PW-1:0] rd_ptr_q, rd_ptr_d;
    logic [PW:0]   count_q, count_d;
    logic          not_full_q, not_full_d;
    logic          push, pop;

    assign push     = wr.valid && not_full_q;
    assign pop      = rd.ready && (count_q != '0);
    assign wr.ready = not_full_q;
    assign rd.valid = (count_q != '0);
    assign rd.data  = mem_q[rd_ptr_q];

    always_comb begin
        wr_ptr_d   = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
        rd_ptr_d   = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
        count_d    = count_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
        not_full_d = (count_d != (PW + 1)'(DEPTH));
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            wr_ptr_q   <= '0;
            rd_ptr_q   <= '0;
            count_q    <= '0;
            not_full_q <= 1'b1;
        end else begin
            wr_ptr_q   <= wr_ptr_d;
            rd_ptr_q   <= rd_ptr_d;
            count_q    <= count_d;
            not_full_q <= not_full_d;
        end
    end

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_ptr_q] <= wr.data;
        end
    end

endmodule : bas_fifo

// File: bas_seq_sva.sv
// Port-level assertions for the burst address sequencer.
module bas_seq_sva import bas_pkg::*; #(
    parameter int ADDR_W = 32
) (
    input wire logic              clk_in,
    input wire logic              sys_rst_in,
    input wire logic              cs_n_in,
    input wire logic              cmd_valid_in,
    input wire logic [47:0]       command_address_word_in,
    input wire logic [ADDR_W-1:0] cmd_start_addr_in,
    input wire logic [15:0]       cfg_reg_zero_in,
    input wire logic              byte_valid_in,
    input wire logic              byte_ready_out,
    input wire logic              word_addr_valid_out,
    input wire logic [ADDR_W-1:0] word_addr_out,
    input wire logic              word_addr_ready_in,
    input wire logic              burst_active_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------
    // Burst context seen at the ports
    // ------------------------------
    localparam bas_mask_t MT [4] = '{6'h3F, 6'h1F, 6'h07, 6'h0F};
    logic [1:0]        low_q;
    logic              lin_q, wrap_q, have_q;
    bas_mask_t         m_q;
    logic [ADDR_W-1:0] start_q, prev_q, m;
    // Four low samples, three counted by low_q plus the current one, are required so the check never races the chip-select synchroniser.
    wire go = cmd_valid_in && !cs_n_in && low_q == 2'h3 && !burst_active_out;
    wire take = word_addr_valid_out && word_addr_ready_in;
    assign m = ADDR_W'(m_q);
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            low_q <= 2'h0;
            have_q <= 1'b0;
        end else begin
            low_q <= cs_n_in ? 2'h0 : ((low_q == 2'h3) ? low_q : low_q + 2'h1);
            if (go) begin
                lin_q <= command_address_word_in[45];
                wrap_q <= cfg_reg_zero_in[2];
                m_q <= MT[cfg_reg_zero_in[1:0]];
                start_q <= cmd_start_addr_in;
                have_q <= 1'b0;
            end else if (take) begin
                have_q <= 1'b1;
                prev_q <= word_addr_out;
            end
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_cmd; go; endsequence
    sequence s_cs_gone; cs_n_in [*4]; endsequence
    AST_RST: assert property (disable iff (1'b0)
        sys_rst_in |=> byte_ready_out && !word_addr_valid_out && !burst_active_out)
        else $error("reset state wrong");
    AST_START: assert property (s_cmd |-> ##[1:2] burst_active_out)
        else $error("burst did not start");
    AST_QUIET: assert property (!burst_active_out && !cmd_valid_in && !$past(cmd_valid_in)
        |=> !burst_active_out) else $error("burst without command");
    AST_END: assert property (s_cs_gone |=> !burst_active_out)
        else $error("burst outlived chip select");
    AST_HOLD: assert property (word_addr_valid_out && !word_addr_ready_in
        |=> word_addr_valid_out && $stable(word_addr_out)) else $error("address dropped");
    AST_FIRST: assert property (take && !have_q |-> word_addr_out == start_q)
        else $error("first address wrong");
    AST_LIN: assert property (take && have_q && lin_q |-> word_addr_out == prev_q + 1)
        else $error("linear step wrong");
    AST_WRAP: assert property (take && have_q && !lin_q && wrap_q
        |-> word_addr_out == ((prev_q & ~m) | ((prev_q + 1) & m))) else $error("wrap step wrong");
endmodule : bas_seq_sva

bind bas_burst_address_sequencer bas_seq_sva #(.ADDR_W(ADDR_W)) u_sva (
    .clk_in, .sys_rst_in, .cs_n_in, .cmd_valid_in, .command_address_word_in,
    .cmd_start_addr_in, .cfg_reg_zero_in, .byte_valid_in, .byte_ready_out,
    .word_addr_valid_out, .word_addr_out, .word_addr_ready_in, .burst_active_out
);

// File: bas_host_model.sv
// Host controller model: chip select, command word and data byte strobes.
module bas_host_model (
    input  wire logic   clk_in,
    input  wire logic   byte_ready_in,
    output logic        cs_n_out,
    output logic        cmd_valid_out,
    output logic [47:0] ca_out,
    output logic [31:0] start_out,
    output logic [15:0] cfg_out,
    output logic        byte_valid_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic rdy_s;
    initial begin
        cs_n_out = 1'b1;
        cmd_valid_out = 1'b0;
        ca_out = 48'h0;
        start_out = 32'h0;
        cfg_out = 16'h3;
        byte_valid_out = 1'b0;
    end
    // Sampled mid-cycle so the value read after an edge is the one the edge saw.
    always @(negedge clk_in) rdy_s = byte_ready_in;
    task automatic burst(logic lin, logic hyb, logic [1:0] code, logic [31:0] a, int nb);
        int i;
        @(posedge clk_in);
        cs_n_out <= 1'b0;
        repeat (3) @(posedge clk_in);
        cmd_valid_out <= 1'b1;
        ca_out <= {2'h0, lin, 45'h0};
        start_out <= a;
        cfg_out <= {13'h0, ~hyb, code};
        @(posedge clk_in);
        cmd_valid_out <= 1'b0;
        ca_out <= ~ca_out;
        start_out <= ~a;
        for (i = 0; i < nb; i++) begin
            byte_valid_out <= 1'b1;
            do @(posedge clk_in); while (!rdy_s);
            if ($urandom % 4 == 0) begin
                byte_valid_out <= 1'b0;
                @(posedge clk_in);
            end
        end
        byte_valid_out <= 1'b0;
        cs_n_out <= 1'b1;
        repeat (5) @(posedge clk_in);
    endtask : burst
endmodule : bas_host_model

// File: burst_address_sequencer_bench.sv
// Self-checking bench for the burst address sequencer.
module burst_address_sequencer_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [5:0] MT [4] = '{6'h3F, 6'h1F, 6'h07, 6'h0F};
    localparam logic [31:0] ST [4] = '{32'h1203, 32'h1203, 32'h1202, 32'h120A};
    logic clk_in = 0, sys_rst_in = 1, cs_n_in, cmd_valid_in, byte_valid_in, byte_ready_out;
    logic word_addr_valid_out, word_addr_ready_in = 0, burst_active_out, cur_lin, cur_hyb;
    logic [47:0] command_address_word_in;
    logic [31:0] cmd_start_addr_in, word_addr_out, cur_start;
    logic [15:0] cfg_reg_zero_in;
    logic [1:0]  cur_code;
    int err_total = 0, check_count = 0, idx = 0, rp = 4, c, saw_full = 0;
    bas_burst_address_sequencer dut (
        .clk_in, .sys_rst_in, .cs_n_in, .cmd_valid_in, .command_address_word_in,
        .cmd_start_addr_in, .cfg_reg_zero_in, .byte_valid_in, .byte_ready_out,
        .word_addr_valid_out, .word_addr_out, .word_addr_ready_in, .burst_active_out);
    bas_host_model host (.clk_in, .byte_ready_in(byte_ready_out), .cs_n_out(cs_n_in),
        .cmd_valid_out(cmd_valid_in), .ca_out(command_address_word_in),
        .start_out(cmd_start_addr_in), .cfg_out(cfg_reg_zero_in), .byte_valid_out(byte_valid_in));
    always #12.5 clk_in = ~clk_in;
    always @(posedge clk_in) word_addr_ready_in <= ($urandom % 4) < rp;
    // --------------------
    // Checking and helpers
    // --------------------
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    function automatic logic [31:0] exp_addr(int k);
        logic [31:0] m;
        m = {26'h0, MT[cur_code]};
        if (cur_lin) return cur_start + k;
        if (cur_hyb && k > m) return (cur_start & ~m) + k;
        return (cur_start & ~m) | ((cur_start + k) & m);
    endfunction : exp_addr
    always @(negedge clk_in) begin
        if (byte_ready_out === 1'b0) saw_full = 1;
        if (word_addr_valid_out && word_addr_ready_in) begin
            chk("word_addr", exp_addr(idx), word_addr_out);
            idx++;
        end
    end
    task automatic run(logic lin, logic hyb, logic [1:0] code, logic [31:0] a, int nw, int odd);
        int t;
        cur_lin = lin;
        cur_hyb = hyb;
        cur_code = code;
        cur_start = a;
        idx = 0;
        host.burst(lin, hyb, code, a, 2 * nw + odd);
        @(negedge clk_in);
        for (t = 0; t < 400 && word_addr_valid_out !== 1'b0; t++) @(negedge clk_in);
        chk("drain", 32'h0, {31'h0, word_addr_valid_out});
        chk("word_count", nw, idx);
    endtask : run
    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    // -------------
    // Test sequence
    // -------------
    initial begin
        void'($urandom(96270));
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        chk("reset", 32'h4, {29'h0, byte_ready_out, word_addr_valid_out, burst_active_out});
        @(posedge clk_in);
        sys_rst_in <= 1'b0;
        run(1'b1, 1'b0, 2'h3, ST[0], 22, 0);
        rp = 2;
        for (c = 0; c < 4; c++) begin
            run(1'b0, 1'b0, 2'(c), ST[c], 2 * (MT[c] + 1) + 3, 1);
            run(1'b0, 1'b1, 2'(c), ST[c], MT[c] + 11, 0);
        end
        rp = 1;
        // A slow consumer and a long linear burst over the top of the address space fill the FIFO.
        run(1'b1, 1'b0, 2'h3, 32'hFFFF_FFF0, 80, 1);
        repeat (6) run(1'($urandom), 1'($urandom), 2'($urandom), $urandom, 1 + $urandom % 40, $urandom % 2);
        chk("fifo_full", 1, saw_full);
        end_sim;
    end
    initial begin
        repeat (60000) @(posedge clk_in);
        err_total++;
        end_sim;
    end
endmodule : burst_address_sequencer_bench
